/* touch_press_timing_control_tb.sv */
// Purpose: Self-checking bench for touch press timing control
// Assumes: 1 ms tick shortened to 4 clocks, sampling cycle to 2 ticks
// Notes: Times are judged exactly or, for recal, within a few ticks, matching the block's granularity
`timescale 1ns/100ps
`default_nettype none
module touch_press_timing_control_tb;
  localparam int TK = 4;
  localparam int ST = 2;
  logic clk, reset, reg_we, group_touch, group_slide, group_sample_en, sample_start;
  logic group_tap, group_hold, group_slide_event, alert;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lf_noise, sample_above_noise;
  logic [7:0] recal_sample_keep, analog_cal_retry, hold_recal, d;
  logic [6:0] button_touch, channel_sample_en, button_int;
  int fail_count, n_checks, cyc, n_int, n_any, n_alert, n_hrec0, n_hrec7, n_tap, n_hold, n_slide, t_hrec, k, t0;
  int t_int[4];
  int t_ss[2];

  tptc_top #(.TICK_CYCLES(TK), .SAMPLE_TICKS(ST), .GRP_MAX_DUR_CODE(4'h0)) i_tptc_top (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .button_touch(button_touch), .group_touch(group_touch),
    .group_slide(group_slide), .lf_noise(lf_noise), .sample_above_noise(sample_above_noise),
    .channel_sample_en(channel_sample_en), .group_sample_en(group_sample_en),
    .sample_start(sample_start), .recal_sample_keep(recal_sample_keep),
    .analog_cal_retry(analog_cal_retry), .button_int(button_int), .hold_recal(hold_recal),
    .group_tap(group_tap), .group_hold(group_hold), .group_slide_event(group_slide_event), .alert(alert)
  );

  tptc_host_model i_tptc_host_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata)
  );

  // Event counters and timestamps, sampled where the pulses are settled
  always @(posedge clk) begin
    cyc++;
    if (sample_start === 1'b1) begin
      t_ss[0] = t_ss[1];
      t_ss[1] = cyc;
    end
    if (button_int[0] === 1'b1) begin
      if (n_int < 4) t_int[n_int] = cyc;
      n_int++;
    end
    if (|button_int === 1'b1) n_any++;
    if (alert === 1'b1) n_alert++;
    if (hold_recal[0] === 1'b1) begin
      n_hrec0++;
      t_hrec = cyc;
    end
    if (hold_recal[7] === 1'b1) n_hrec7++;
    if (group_tap === 1'b1) n_tap++;
    if (group_hold === 1'b1) n_hold++;
    if (group_slide_event === 1'b1) n_slide++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic clr();
    @(negedge clk);
    {n_int, n_any, n_alert, n_hrec0, n_hrec7, n_tap, n_hold, n_slide} = '0;
  endtask

  task automatic hold_ms(input int n);
    repeat (n * TK) @(negedge clk);
  endtask

  task automatic t_regs();
    i_tptc_host_model.rd(8'h20, d);
    chk("config reset", d, 8'h29);
    i_tptc_host_model.rd(8'h21, d);
    chk("enable reset", d, 8'hFF);
    i_tptc_host_model.rd(8'h22, d);
    chk("button cfg reset", d, 8'hA4);
    i_tptc_host_model.rd(8'h23, d);
    chk("group cfg reset", d, 8'h47);
    chk("chan en out", channel_sample_en, 7'h7F);
    chk("group en out", group_sample_en, 1'b1);
    // Back-to-back writes, then readback
    i_tptc_host_model.wr(8'h22, 8'h5A);
    i_tptc_host_model.wr(8'h23, 8'hC3);
    i_tptc_host_model.wr(8'h40, 8'h5A);
    i_tptc_host_model.rd(8'h22, d);
    chk("button cfg rw", d, 8'h5A);
    i_tptc_host_model.rd(8'h23, d);
    chk("group cfg rw", d, 8'hC3);
    i_tptc_host_model.rd(8'h40, d);
    chk("unmapped read", d, 8'h00);
    i_tptc_host_model.wr(8'h22, 8'hA4);
    i_tptc_host_model.wr(8'h23, 8'h47);
    $display("t_regs done");
  endtask

  task automatic t_enable();
    hold_ms(ST * 3);
    chk("cycle length", t_ss[1] - t_ss[0], ST * TK);
    i_tptc_host_model.wr(8'h21, 8'h00);
    hold_ms(ST * 3);
    chk("cycle length off", t_ss[1] - t_ss[0], ST * TK);
    chk("chan en off", channel_sample_en, 7'h00);
    chk("group en off", group_sample_en, 1'b0);
    clr();
    button_touch = 7'h7F;
    group_touch = 1'b1;
    hold_ms(20);
    button_touch = 7'h00;
    group_touch = 1'b0;
    hold_ms(3);
    chk("disabled buttons", n_any, 0);
    chk("disabled group", n_tap + n_hold, 0);
    i_tptc_host_model.wr(8'h21, 8'hFF);
    $display("t_enable done");
  endtask

  task automatic t_noise();
    clr();
    lf_noise = 8'h01;
    sample_above_noise = 8'h5B;
    hold_ms(1);
    chk("keep all", recal_sample_keep, 8'hFF);
    chk("retry on", analog_cal_retry, 8'h01);
    button_touch = 7'h01;
    hold_ms(20);
    button_touch = 7'h00;
    hold_ms(2);
    chk("noise blocks", n_int, 0);
    i_tptc_host_model.wr(8'h20, 8'h19);
    hold_ms(1);
    chk("keep quiet", recal_sample_keep, 8'hA4);
    chk("retry off", analog_cal_retry, 8'h00);
    button_touch = 7'h01;
    i_tptc_host_model.rd(8'h30, d);
    chk("status touch", d, 8'h01);
    hold_ms(20);
    button_touch = 7'h00;
    hold_ms(2);
    chk("noise ignored", n_int, 1);
    chk("alert count", n_alert, 1);
    lf_noise = 8'h00;
    sample_above_noise = 8'h00;
    i_tptc_host_model.wr(8'h20, 8'h29);
    $display("t_noise done");
  endtask

  task automatic t_repeat();
    clr();
    button_touch = 7'h01;
    hold_ms(200);
    button_touch = 7'h00;
    hold_ms(5);
    chk("single int", n_int, 1);
    i_tptc_host_model.wr(8'h20, 8'h2D);
    for (int c = 0; c < 4; c += 3) begin
      i_tptc_host_model.wr(8'h22, {4'hF, 4'(c)});
      clr();
      button_touch = 7'h01;
      hold_ms(3 * (c + 1) * 35 + 10);
      button_touch = 7'h00;
      chk("repeat gap", t_int[2] - t_int[1], (c + 1) * 35 * TK);
      hold_ms(1);
      k = n_int;
      hold_ms(2 * (c + 1) * 35);
      chk("stop on release", n_int, k);
    end
    i_tptc_host_model.wr(8'h20, 8'h29);
    i_tptc_host_model.wr(8'h22, 8'hA4);
    $display("t_repeat done");
  endtask

  task automatic t_maxdur();
    int lim[2];
    lim = '{560, 840};
    for (int c = 0; c < 2; c++) begin
      i_tptc_host_model.wr(8'h22, {4'(c), 4'h4});
      clr();
      t0 = cyc;
      button_touch = 7'h01;
      hold_ms(lim[c] + 20);
      button_touch = 7'h00;
      hold_ms(2);
      chk("recal count", n_hrec0, 1);
      chk("recal time", (t_hrec - t0 >= (lim[c] - 1) * TK) && (t_hrec - t0 <= (lim[c] + 3) * TK), 1);
    end
    i_tptc_host_model.wr(8'h20, 8'h21);
    clr();
    button_touch = 7'h01;
    hold_ms(900);
    button_touch = 7'h00;
    hold_ms(2);
    chk("recal off", n_hrec0, 0);
    i_tptc_host_model.wr(8'h20, 8'h29);
    i_tptc_host_model.wr(8'h22, 8'hA4);
    $display("t_maxdur done");
  endtask

  task automatic t_group();
    clr();
    group_touch = 1'b1;
    hold_ms(200);
    group_touch = 1'b0;
    hold_ms(3);
    chk("tap", n_tap, 1);
    chk("no hold", n_hold, 0);
    clr();
    group_touch = 1'b1;
    hold_ms(350);
    group_slide = 1'b1;
    @(negedge clk);
    group_slide = 1'b0;
    hold_ms(250);
    group_touch = 1'b0;
    hold_ms(3);
    chk("hold repeats", n_hold, 2);
    chk("no tap", n_tap, 0);
    chk("slide", n_slide, 1);
    chk("group recal off", n_hrec7, 0);
    i_tptc_host_model.wr(8'h20, 8'h2A);
    clr();
    group_touch = 1'b1;
    hold_ms(600);
    group_touch = 1'b0;
    hold_ms(3);
    chk("single hold", n_hold, 1);
    chk("group recal", n_hrec7, 1);
    i_tptc_host_model.wr(8'h20, 8'h29);
    i_tptc_host_model.wr(8'h23, 8'h00);
    clr();
    group_touch = 1'b1;
    hold_ms(20);
    group_touch = 1'b0;
    hold_ms(3);
    chk("short tap", n_tap, 1);
    i_tptc_host_model.wr(8'h23, 8'h47);
    $display("t_group done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    button_touch = 7'h00;
    group_touch = 1'b0;
    group_slide = 1'b0;
    lf_noise = 8'h00;
    sample_above_noise = 8'h00;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_enable();
    t_noise();
    t_repeat();
    t_maxdur();
    t_group();
    stop_test();
  end

  // About three times the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

/* tptc_host_model.sv */
// Purpose: Host-side model driving the single-cycle register port of the block
// Assumes: Bench calls the tasks; signals change only at falling clock edges
// Notes: Write data is inverted after the strobe so stale values are never read as fresh
`timescale 1ns/100ps
`default_nettype none
module tptc_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
  end

  // Strobe spans exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* tptc_pkg.sv */
// Purpose: Shared constants, types and decoders for touch press timing control
// Assumes: 250 MHz core clock, millisecond time base derived from it
// Notes: All offsets, reset values, bit positions and timing figures live here
package tptc_pkg;

  localparam logic [7:0] ADDR_CONFIG = 8'h20;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h21;
  localparam logic [7:0] ADDR_BTN_CFG = 8'h22;
  localparam logic [7:0] ADDR_GRP_CFG1 = 8'h23;
  localparam logic [7:0] ADDR_STATUS = 8'h30;

  localparam logic [7:0] RST_CONFIG = 8'h29;
  localparam logic [7:0] RST_CHAN_EN = 8'hFF;
  localparam logic [7:0] RST_BTN_CFG = 8'hA4;
  localparam logic [7:0] RST_GRP_CFG1 = 8'h47;

  localparam int CFG_DIG_NOISE_BIT = 5;
  localparam int CFG_ANA_NOISE_BIT = 4;
  localparam int CFG_UNG_MAXDUR_BIT = 3;
  localparam int CFG_UNG_RPT_BIT = 2;
  localparam int CFG_GRP_MAXDUR_BIT = 1;
  localparam int CFG_GRP_RPT_BIT = 0;
  localparam int CHAN_EN_GROUP_BIT = 7;
  localparam int NUM_BUTTONS = 7;

  // Grouped max-duration code sits in a register outside this block
  localparam logic [3:0] GRP_MAX_DUR_DEFAULT = 4'hD;

  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_CYCLE_MS = 35;

  localparam logic [13:0] STEP_MS = 14'h0023;

  typedef logic [13:0] tptc_ms_t;

  typedef enum logic [1:0] {
    TPTC_G_IDLE = 2'b00,
    TPTC_G_PRESS = 2'b01,
    TPTC_G_HOLD = 2'b10
  } tptc_grp_state_t;

  function automatic tptc_ms_t tptc_max_dur_ms(input logic [3:0] code);
    case (code)
      4'h0: tptc_max_dur_ms = 14'd560;
      4'h1: tptc_max_dur_ms = 14'd840;
      4'h2: tptc_max_dur_ms = 14'd1120;
      4'h3: tptc_max_dur_ms = 14'd1400;
      4'h4: tptc_max_dur_ms = 14'd1680;
      4'h5: tptc_max_dur_ms = 14'd2240;
      4'h6: tptc_max_dur_ms = 14'd2800;
      4'h7: tptc_max_dur_ms = 14'd3360;
      4'h8: tptc_max_dur_ms = 14'd3920;
      4'h9: tptc_max_dur_ms = 14'd4480;
      4'hA: tptc_max_dur_ms = 14'd5600;
      4'hB: tptc_max_dur_ms = 14'd6720;
      4'hC: tptc_max_dur_ms = 14'd7840;
      4'hD: tptc_max_dur_ms = 14'd8906;
      4'hE: tptc_max_dur_ms = 14'd10080;
      default: tptc_max_dur_ms = 14'd11200;
    endcase
  endfunction

  // Repeat intervals and minimum press share one step decode
  function automatic tptc_ms_t tptc_step_ms(input logic [3:0] code);
    tptc_step_ms = tptc_ms_t'(({10'h000, code} + 14'h0001) * STEP_MS);
  endfunction

endpackage

/* tptc_press_timer.sv */
// Purpose: Per-channel press duration, auto-repeat and hold recalibration timer
// Assumes: touched is already qualified by enables and noise blocking
// Notes: Duration saturates so a stuck press cannot wrap and recalibrate twice
`timescale 1ns/100ps
`default_nettype none
module tptc_press_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic ms_tick,
  input wire logic touched,
  input wire logic [13:0] hold_limit_ms,
  input wire logic [13:0] repeat_ms,
  input wire logic repeat_en,
  input wire logic hold_recal_en,
  output logic touch_event,
  output logic repeat_event,
  output logic recal_event
);
  logic touched_d_r;
  logic [13:0] dur_r;
  logic [13:0] rpt_r;
  logic recal_done_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      touched_d_r <= 1'b0;
      touch_event <= 1'b0;
    end else begin
      touched_d_r <= touched;
      touch_event <= touched && !touched_d_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !touched) begin
      dur_r <= 14'h0000;
    end else if (ms_tick && dur_r != 14'h3FFF) begin
      dur_r <= dur_r + 14'h0001;
    end
  end

  // Repeat count restarts at the first touch and dies with the release
  always_ff @(posedge clk) begin
    if (reset || !touched || !touched_d_r) begin
      rpt_r <= 14'h0000;
      repeat_event <= 1'b0;
    end else if (ms_tick && repeat_en && rpt_r + 14'h0001 >= repeat_ms) begin
      rpt_r <= 14'h0000;
      repeat_event <= 1'b1;
    end else begin
      if (ms_tick) begin
        rpt_r <= rpt_r + 14'h0001;
      end
      repeat_event <= 1'b0;
    end
  end

  // Fires once the press has lasted longer than the limit
  always_ff @(posedge clk) begin
    if (reset || !touched) begin
      recal_done_r <= 1'b0;
      recal_event <= 1'b0;
    end else if (ms_tick && hold_recal_en && !recal_done_r && dur_r >= hold_limit_ms) begin
      recal_done_r <= 1'b1;
      recal_event <= 1'b1;
    end else begin
      recal_event <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tptc_time_base.sv */
// Purpose: Millisecond tick and fixed-length sampling cycle strobe
// Assumes: TICK_CYCLES core clocks make one millisecond
// Notes: Cycle length never depends on which channels are enabled
`timescale 1ns/100ps
`default_nettype none
module tptc_time_base #(
  parameter int TICK_CYCLES = tptc_pkg::TICK_CYCLES,
  parameter int SAMPLE_TICKS = tptc_pkg::SAMPLE_CYCLE_MS
) (
  input wire logic clk,
  input wire logic reset,
  output logic ms_tick,
  output logic sample_start
);
  logic [31:0] div_r;
  logic [31:0] smp_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      div_r <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_r <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      div_r <= div_r + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      smp_r <= 32'h00000000;
      sample_start <= 1'b0;
    end else if (ms_tick && smp_r == 32'(SAMPLE_TICKS - 1)) begin
      smp_r <= 32'h00000000;
      sample_start <= 1'b1;
    end else begin
      if (ms_tick) begin
        smp_r <= smp_r + 32'h00000001;
      end
      sample_start <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tptc_top.sv */
// Purpose: Touch qualification, sampling enables and press timing for buttons and group
// Assumes: Detector inputs are synchronous to clk; register port is single cycle
// Notes: Event outputs are one-cycle pulses, but group_slide_event follows group_slide; alert is the registered OR of all of them except hold_recal
// Functional notes
// - Digital noise bit low drops noisy recal samples
// - Analog block bit low: noise blocks, retries cal
// - Analog block bit high: no block, no retry
// - Ungrouped overlong press restarts recalibration when enabled
// - Ungrouped: one interrupt, or auto-repeat when enabled
// - Grouped overlong press restarts recalibration when enabled
// - Grouped hold: single interrupt, repeats when enabled
// - Low enable bits gate channels one-seven, reset on
// - Sampling cycle length fixed regardless of enables
// - Group enable low stops all grouped sampling
// - Button config: hold limit high, repeat low
// - Hold limit code decodes to sixteen times
// - Repeat interrupts spaced by selected interval
// - Repeat code decodes (code+1) times 35 ms
// - Group config high nibble: hold repeat interval
// - Group low nibble: minimum press, then hold
// - Grouped touch within minimum press is tap
// - Slides reported separately from press-and-hold
`timescale 1ns/100ps
`default_nettype none
module tptc_top #(
  parameter int TICK_CYCLES = tptc_pkg::TICK_CYCLES,
  parameter int SAMPLE_TICKS = tptc_pkg::SAMPLE_CYCLE_MS,
  parameter logic [3:0] GRP_MAX_DUR_CODE = tptc_pkg::GRP_MAX_DUR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  output logic [7:0] reg_rdata,
  input wire logic [6:0] button_touch,
  input wire logic group_touch,
  input wire logic group_slide,
  input wire logic [7:0] lf_noise,
  input wire logic [7:0] sample_above_noise,
  output logic [6:0] channel_sample_en,
  output logic group_sample_en,
  output logic sample_start,
  output logic [7:0] recal_sample_keep,
  output logic [7:0] analog_cal_retry,
  output logic [6:0] button_int,
  output logic [7:0] hold_recal,
  output logic group_tap,
  output logic group_hold,
  output logic group_slide_event,
  output logic alert
);
  logic [7:0] config_r;
  logic [7:0] chan_en_r;
  logic [7:0] btn_cfg_r;
  logic [7:0] grp_cfg1_r;
  logic ms_tick;
  logic [7:0] noise_block;
  logic [6:0] btn_q;
  logic grp_q;
  logic [6:0] btn_touch_ev;
  logic [6:0] btn_rpt_ev;
  logic [13:0] ung_limit_ms;
  logic [13:0] ung_rpt_ms;
  logic [13:0] ph_rpt_ms;
  logic [13:0] mpress_ms;
  logic [13:0] grp_dur_r;
  logic [13:0] grp_rpt_r;
  logic grp_recal_ev;
  logic [7:0] hold_recal_nxt;
  logic grp_hold_nxt;
  logic grp_tap_nxt;
  tptc_pkg::tptc_grp_state_t grp_state_r;
  tptc_pkg::tptc_grp_state_t grp_state_nxt;

  always_ff @(posedge clk) begin
    if (reset) begin
      config_r <= tptc_pkg::RST_CONFIG;
      chan_en_r <= tptc_pkg::RST_CHAN_EN;
      btn_cfg_r <= tptc_pkg::RST_BTN_CFG;
      grp_cfg1_r <= tptc_pkg::RST_GRP_CFG1;
    end else if (reg_we) begin
      case (reg_addr)
        tptc_pkg::ADDR_CONFIG: config_r <= reg_wdata;
        tptc_pkg::ADDR_CHAN_EN: chan_en_r <= reg_wdata;
        tptc_pkg::ADDR_BTN_CFG: btn_cfg_r <= reg_wdata;
        tptc_pkg::ADDR_GRP_CFG1: grp_cfg1_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      tptc_pkg::ADDR_CONFIG: reg_rdata = config_r;
      tptc_pkg::ADDR_CHAN_EN: reg_rdata = chan_en_r;
      tptc_pkg::ADDR_BTN_CFG: reg_rdata = btn_cfg_r;
      tptc_pkg::ADDR_GRP_CFG1: reg_rdata = grp_cfg1_r;
      tptc_pkg::ADDR_STATUS: reg_rdata = {grp_q, btn_q};
      default: reg_rdata = 8'h00;
    endcase
  end

  tptc_time_base #(
    .TICK_CYCLES(TICK_CYCLES),
    .SAMPLE_TICKS(SAMPLE_TICKS)
  ) u_time_base (
    .clk(clk),
    .reset(reset),
    .ms_tick(ms_tick),
    .sample_start(sample_start)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      channel_sample_en <= 7'h7F;
      group_sample_en <= 1'b1;
    end else begin
      channel_sample_en <= chan_en_r[6:0];
      group_sample_en <= chan_en_r[tptc_pkg::CHAN_EN_GROUP_BIT];
    end
  end

  // Noise blocking also stops the analog calibration retry when disabled
  assign noise_block = lf_noise & {8{~config_r[tptc_pkg::CFG_ANA_NOISE_BIT]}};
  assign btn_q = button_touch & chan_en_r[6:0] & ~noise_block[6:0];
  assign grp_q = group_touch & chan_en_r[tptc_pkg::CHAN_EN_GROUP_BIT] & ~noise_block[7];

  always_ff @(posedge clk) begin
    if (reset) begin
      recal_sample_keep <= 8'hFF;
      analog_cal_retry <= 8'h00;
    end else begin
      recal_sample_keep <= ~sample_above_noise | {8{config_r[tptc_pkg::CFG_DIG_NOISE_BIT]}};
      analog_cal_retry <= noise_block;
    end
  end

  assign ung_limit_ms = tptc_pkg::tptc_max_dur_ms(btn_cfg_r[7:4]);
  assign ung_rpt_ms = tptc_pkg::tptc_step_ms(btn_cfg_r[3:0]);
  assign ph_rpt_ms = tptc_pkg::tptc_step_ms(grp_cfg1_r[7:4]);
  assign mpress_ms = tptc_pkg::tptc_step_ms(grp_cfg1_r[3:0]);

  genvar gi;
  generate
    for (gi = 0; gi < tptc_pkg::NUM_BUTTONS; gi++) begin : g_btn
      tptc_press_timer u_timer (
        .clk(clk),
        .reset(reset),
        .ms_tick(ms_tick),
        .touched(btn_q[gi]),
        .hold_limit_ms(ung_limit_ms),
        .repeat_ms(ung_rpt_ms),
        .repeat_en(config_r[tptc_pkg::CFG_UNG_RPT_BIT]),
        .hold_recal_en(config_r[tptc_pkg::CFG_UNG_MAXDUR_BIT]),
        .touch_event(btn_touch_ev[gi]),
        .repeat_event(btn_rpt_ev[gi]),
        .recal_event(hold_recal_nxt[gi])
      );
    end
  endgenerate

  tptc_press_timer u_grp_timer (
    .clk(clk),
    .reset(reset),
    .ms_tick(ms_tick),
    .touched(grp_q),
    .hold_limit_ms(tptc_pkg::tptc_max_dur_ms(GRP_MAX_DUR_CODE)),
    .repeat_ms(ph_rpt_ms),
    .repeat_en(1'b0),
    .hold_recal_en(config_r[tptc_pkg::CFG_GRP_MAXDUR_BIT]),
    .touch_event(),
    .repeat_event(),
    .recal_event(grp_recal_ev)
  );
  assign hold_recal_nxt[7] = grp_recal_ev;

  // Group duration counts whole milliseconds of one continuous touch
  always_ff @(posedge clk) begin
    if (reset || grp_state_r == tptc_pkg::TPTC_G_IDLE) begin
      grp_dur_r <= 14'h0000;
    end else if (ms_tick && grp_dur_r != 14'h3FFF) begin
      grp_dur_r <= grp_dur_r + 14'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || grp_state_r != tptc_pkg::TPTC_G_HOLD || !grp_q) begin
      grp_rpt_r <= 14'h0000;
    end else if (ms_tick) begin
      grp_rpt_r <= (grp_rpt_r + 14'h0001 >= ph_rpt_ms) ? 14'h0000 : grp_rpt_r + 14'h0001;
    end
  end

  always_comb begin
    grp_state_nxt = grp_state_r;
    grp_hold_nxt = 1'b0;
    grp_tap_nxt = 1'b0;
    case (grp_state_r)
      tptc_pkg::TPTC_G_IDLE: begin
        if (grp_q) begin
          grp_state_nxt = tptc_pkg::TPTC_G_PRESS;
        end
      end
      tptc_pkg::TPTC_G_PRESS: begin
        if (!grp_q) begin
          grp_tap_nxt = 1'b1;
          grp_state_nxt = tptc_pkg::TPTC_G_IDLE;
        end else if (ms_tick && grp_dur_r >= mpress_ms) begin
          grp_hold_nxt = 1'b1;
          grp_state_nxt = tptc_pkg::TPTC_G_HOLD;
        end
      end
      tptc_pkg::TPTC_G_HOLD: begin
        if (!grp_q) begin
          grp_state_nxt = tptc_pkg::TPTC_G_IDLE;
        end else if (ms_tick && config_r[tptc_pkg::CFG_GRP_RPT_BIT] && grp_rpt_r + 14'h0001 >= ph_rpt_ms) begin
          grp_hold_nxt = 1'b1;
        end
      end
      default: grp_state_nxt = tptc_pkg::TPTC_G_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      grp_state_r <= tptc_pkg::TPTC_G_IDLE;
    end else begin
      grp_state_r <= grp_state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      button_int <= 7'h00;
      hold_recal <= 8'h00;
      group_tap <= 1'b0;
      group_hold <= 1'b0;
      group_slide_event <= 1'b0;
    end else begin
      button_int <= btn_touch_ev | btn_rpt_ev;
      hold_recal <= hold_recal_nxt;
      group_tap <= grp_tap_nxt;
      group_hold <= grp_hold_nxt;
      // Slides bypass the hold classifier so both can be reported
      group_slide_event <= group_slide & grp_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alert <= 1'b0;
    end else begin
      alert <= |{button_int, group_tap, group_hold, group_slide_event};
    end
  end

  sequence s_grp_release;
    grp_state_r == tptc_pkg::TPTC_G_PRESS && !grp_q;
  endsequence

  sequence s_hold_reached;
    grp_state_r == tptc_pkg::TPTC_G_PRESS && grp_q && ms_tick && grp_dur_r >= mpress_ms;
  endsequence

  property p_dig_noise;
    @(posedge clk) disable iff (reset)
      (!config_r[tptc_pkg::CFG_DIG_NOISE_BIT] && sample_above_noise[0]) |=> !recal_sample_keep[0];
  endproperty
  a_dig_noise: assert property (p_dig_noise) else $error("noisy sample kept");

  property p_ana_block;
    @(posedge clk) disable iff (reset)
      (!config_r[tptc_pkg::CFG_ANA_NOISE_BIT] && lf_noise[0]) |-> (!btn_q[0] ##1 analog_cal_retry[0]);
  endproperty
  a_ana_block: assert property (p_ana_block) else $error("noise did not block");

  property p_ana_pass;
    @(posedge clk) disable iff (reset)
      config_r[tptc_pkg::CFG_ANA_NOISE_BIT] |=> analog_cal_retry == 8'h00;
  endproperty
  a_ana_pass: assert property (p_ana_pass) else $error("retry while blocking off");

  property p_single_int;
    @(posedge clk) disable iff (reset)
      (!config_r[tptc_pkg::CFG_UNG_RPT_BIT] && $rose(btn_q[0])) |=> ##1 button_int[0] ##1 !button_int[0] [*4];
  endproperty
  a_single_int: assert property (p_single_int) else $error("button interrupt wrong");

  property p_grp_norpt;
    @(posedge clk) disable iff (reset)
      (grp_state_r == tptc_pkg::TPTC_G_HOLD && !config_r[tptc_pkg::CFG_GRP_RPT_BIT]) |=> !group_hold;
  endproperty
  a_grp_norpt: assert property (p_grp_norpt) else $error("hold repeated");

  property p_chan_en;
    @(posedge clk) disable iff (reset)
      ##1 channel_sample_en == $past(chan_en_r[6:0]);
  endproperty
  a_chan_en: assert property (p_chan_en) else $error("channel enable mismatch");

  property p_sample_fixed;
    @(posedge clk) disable iff (reset)
      sample_start |=> !sample_start [*7];
  endproperty
  a_sample_fixed: assert property (p_sample_fixed) else $error("sample cycle short");

  property p_grp_off;
    @(posedge clk) disable iff (reset)
      !chan_en_r[tptc_pkg::CHAN_EN_GROUP_BIT] |-> !grp_q ##1 !group_sample_en;
  endproperty
  a_grp_off: assert property (p_grp_off) else $error("group sampled while off");

  property p_hold_event;
    @(posedge clk) disable iff (reset)
      s_hold_reached |=> group_hold && !group_tap;
  endproperty
  a_hold_event: assert property (p_hold_event) else $error("hold not reported");

  property p_tap_event;
    @(posedge clk) disable iff (reset)
      s_grp_release |=> group_tap && !group_hold;
  endproperty
  a_tap_event: assert property (p_tap_event) else $error("tap not reported");

  property p_slide;
    @(posedge clk) disable iff (reset)
      (group_slide && grp_q) |=> group_slide_event;
  endproperty
  a_slide: assert property (p_slide) else $error("slide lost");

  property p_rpt_stop;
    @(posedge clk) disable iff (reset)
      (!btn_q[0] [*2]) |=> !button_int[0];
  endproperty
  a_rpt_stop: assert property (p_rpt_stop) else $error("repeat after release");

endmodule
`default_nettype wire
